// ===== verilog/can_txsel_pkg.sv
// Constants, field layouts and carrier types for the transmit select,
// abort acknowledge and acceptance control block.
// Assumes an APB slave at word granularity with an 8-bit byte address.
//
// Notes on behaviour
// - Initialization mode holds abort acknowledge at reset.
// - One abort acknowledge flag per buffer, bits 2:0.
// - Clearing a buffer empty flag clears its acknowledge.
// - Abort acknowledge flags ignore writes, read anytime.
// - Lowest set select bit maps buffer into window.
// - Select read returns only the lowest set bit.
// - Select writable outside init, reset during init.
// - Window blocked while selected buffer is scheduled.
// - No buffer selected means no window access.
// - Acceptance control writable only in init; hit read-only.
// - Mode 00/01/10/11: 2x32, 4x16, 8x8, closed.
// - Closed filter accepts nothing; foreground never reloaded.
// - Hit index reports matched filter number 0 to 7.
// - Hit index updates when foreground buffer loads.
// - Reserved test registers read zero, ignore writes.
// - Empty flag sets on send success or abort.
// - Abort granted if unstarted or failed; empty sets, request clears.

package can_txsel_pkg;

  localparam int DATA_W    = 32;
  localparam int NBUF      = 3;
  localparam int WIN_WORDS = 4;
  localparam int IDX_W     = 6;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_TX_FLAG   = 6'h06;
  localparam logic [IDX_W-1:0] IDX_ABORT_REQ = 6'h08;
  localparam logic [IDX_W-1:0] IDX_ABORT_ACK = 6'h09;
  localparam logic [IDX_W-1:0] IDX_TX_SEL    = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_ACC_CTRL  = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_TEST_LO   = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_TEST_HI   = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_WIN_BASE  = 6'h20;

  // Field positions.
  localparam int BUF_MSB  = 2;
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 5;
  localparam int HIT_MSB  = 2;

  // Reset values.
  localparam logic [NBUF-1:0] TX_EMPTY_RST = 3'h7;
  localparam logic [NBUF-1:0] BUF_ZERO     = 3'h0;
  localparam logic [2:0]      HIT_RST      = 3'h0;
  localparam logic [7:0]      BYTE_ZERO    = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h00000000;

  typedef enum logic [1:0]
  {
    ACC_TWO_32   = 2'b00,
    ACC_FOUR_16  = 2'b01,
    ACC_EIGHT_8  = 2'b10,
    ACC_CLOSED   = 2'b11
  } acc_mode_t;

  // Status from the transmit engine, one bit per buffer.
  typedef struct packed
  {
    logic [NBUF-1:0] busy;
    logic [NBUF-1:0] sent;
    logic [NBUF-1:0] failed;
  } tx_status_t;

  // A message ready to move into the receive foreground buffer.
  typedef struct packed
  {
    logic       shift;
    logic [2:0] hit;
  } rx_event_t;

endpackage : can_txsel_pkg

// ===== verilog/lowest_set_pick.sv
// Isolates the lowest set bit of a vector as a one-hot value.
// Purely combinational; the caller registers the result if needed.

`timescale 1ns/1ps

module lowest_set_pick #(
  parameter int W = 3
) (
  input  wire logic [W-1:0] vec,
  output logic      [W-1:0] onehot
);

  // Two's complement leaves only the lowest one in common with vec.
  assign onehot = vec & (~vec + W'(1));

endmodule : lowest_set_pick

// ===== verilog/can_tx_select_abort_filter_ctrl.sv
// Transmit flags, abort request and acknowledge, transmit buffer select
// with its access window, and identifier acceptance control.
// Assumes an APB master on pclk and a transmit engine and receiver that
// report through the tx_status_t and rx_event_t carriers.
//
// Implementation choice: the APB register port.

`timescale 1ns/1ps

module can_tx_select_abort_filter_ctrl
  import can_txsel_pkg::*;
#(
  parameter int WORDS = WIN_WORDS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              init_request,
  input  wire logic              init_acknowledge,
  input  wire tx_status_t        tx_stat,
  input  wire rx_event_t         rx_evt,
  input  wire logic [1:0]        fetch_buf,
  input  wire logic [1:0]        fetch_word,
  output logic      [7:0]        fetch_data,
  output logic      [NBUF-1:0]   tx_empty,
  output logic      [NBUF-1:0]   tx_window_sel,
  output logic                   rx_fg_load,
  output acc_mode_t              acc_mode
);

  function automatic int unsigned mem_index(input logic [1:0] b,
                                            input logic [1:0] w);
    int unsigned bi;
    bi = (b >= 2'(NBUF)) ? 0 : int'(b);
    return bi * WORDS + int'(w);
  endfunction : mem_index

  function automatic logic [1:0] onehot_to_idx(input logic [NBUF-1:0] oh);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < NBUF; i++)
    begin
      if (oh[i])
        r = 2'(i);
    end
    return r;
  endfunction : onehot_to_idx

  logic [DATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [NBUF-1:0]   tx_empty_q;
  logic [NBUF-1:0]   abort_req_q;
  logic [NBUF-1:0]   abort_ack_q;
  logic [NBUF-1:0]   tx_sel_q;
  logic [NBUF-1:0]   tx_window_sel_q;
  acc_mode_t         acc_mode_q;
  logic [2:0]        hit_q;
  logic              rx_fg_load_q;
  logic [7:0]        fetch_data_q;
  logic [7:0]        win_mem_q [NBUF*WORDS];

  logic              in_init;
  logic              out_init;
  logic [IDX_W-1:0]  idx;
  logic              setup;
  logic              wr_en;
  logic              win_hit;
  logic [1:0]        win_word;
  logic [NBUF-1:0]   win_sel;
  logic              win_open;
  logic [NBUF-1:0]   abort_grant;
  logic [NBUF-1:0]   tx_set;
  logic [NBUF-1:0]   sw_clr;
  logic [NBUF-1:0]   txe_clear;
  logic              filter_closed;
  logic [DATA_W-1:0] rd_word;
  logic              rd_err;

  assign in_init  = init_request & init_acknowledge;
  assign out_init = ~init_request & ~init_acknowledge;
  assign idx      = paddr[7:2];
  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pready_q & pwrite;
  assign win_hit  = (idx >= IDX_WIN_BASE) &&
                    (idx < IDX_WIN_BASE + IDX_W'(WORDS));
  assign win_word = 2'(idx - IDX_WIN_BASE);

  lowest_set_pick #(
    .W      (NBUF)
  ) u_sel_pick (
    .vec    (tx_sel_q),
    .onehot (win_sel)
  );

  // Only the lowest selected buffer is reachable, and only while empty.
  assign win_open = |(win_sel & tx_empty_q);

  // An abort is granted before the frame starts or after it fails.
  assign abort_grant = abort_req_q & ~tx_empty_q &
                       (~tx_stat.busy | tx_stat.failed);
  assign tx_set      = (tx_stat.sent | abort_grant) & ~tx_empty_q;
  assign sw_clr      = (wr_en && idx == IDX_TX_FLAG) ?
                       pwdata[BUF_MSB:0] : BUF_ZERO;
  assign txe_clear   = sw_clr & tx_empty_q & ~tx_set;
  assign filter_closed = (acc_mode_q == ACC_CLOSED);

  // Writing a one clears an empty flag; a hardware set in the same cycle
  // wins, so a finished frame is never reported as still scheduled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_empty_q <= TX_EMPTY_RST;
    else
      tx_empty_q <= (tx_empty_q & ~txe_clear) | tx_set;
  end

  // The engine's own clear on empty takes priority over a fresh request.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      abort_req_q <= BUF_ZERO;
    else if (in_init)
      abort_req_q <= BUF_ZERO;
    else if (wr_en && idx == IDX_ABORT_REQ && out_init)
      abort_req_q <= (abort_req_q | (pwdata[BUF_MSB:0] & ~tx_empty_q))
                     & ~tx_set;
    else
      abort_req_q <= abort_req_q & ~tx_set;
  end

  // Only a write that clears an empty flag reaches the acknowledge flags.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      abort_ack_q <= BUF_ZERO;
    else if (in_init)
      abort_ack_q <= BUF_ZERO;
    else
      abort_ack_q <= (abort_ack_q & ~txe_clear) | abort_grant;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_sel_q <= BUF_ZERO;
    else if (in_init)
      tx_sel_q <= BUF_ZERO;
    else if (wr_en && idx == IDX_TX_SEL && out_init)
      tx_sel_q <= pwdata[BUF_MSB:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_window_sel_q <= BUF_ZERO;
    else
      tx_window_sel_q <= win_open ? win_sel : BUF_ZERO;
  end

  // Window storage; writes land only in the selected, empty buffer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NBUF*WORDS; i++)
        win_mem_q[i] <= BYTE_ZERO;
    end
    else if (wr_en && win_hit && win_open)
      win_mem_q[mem_index(onehot_to_idx(win_sel), win_word)] <=
        pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fetch_data_q <= BYTE_ZERO;
    else
      fetch_data_q <= win_mem_q[mem_index(fetch_buf, fetch_word)];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_mode_q <= ACC_TWO_32;
    else if (wr_en && idx == IDX_ACC_CTRL && in_init)
      acc_mode_q <= acc_mode_t'(pwdata[MODE_MSB:MODE_LSB]);
  end

  // The hit index follows the foreground buffer and nothing else.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hit_q <= HIT_RST;
    else if (rx_evt.shift && !filter_closed)
      hit_q <= rx_evt.hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_fg_load_q <= 1'b0;
    else
      rx_fg_load_q <= rx_evt.shift & ~filter_closed;
  end

  // Read data is sampled in the setup cycle, so a flag that changes during
  // the one-cycle access phase shows on the next read.
  always_comb
  begin
    rd_word = WORD_ZERO;
    rd_err  = 1'b0;
    if (win_hit)
    begin
      if (win_open)
        rd_word[7:0] = win_mem_q[mem_index(onehot_to_idx(win_sel),
                                           win_word)];
      else
        rd_err = 1'b1;
    end
    else
    begin
      case (idx)
        IDX_TX_FLAG:   rd_word[BUF_MSB:0] = tx_empty_q;
        IDX_ABORT_REQ: rd_word[BUF_MSB:0] = abort_req_q;
        IDX_ABORT_ACK: rd_word[BUF_MSB:0] = abort_ack_q;
        IDX_TX_SEL:    rd_word[BUF_MSB:0] = win_sel;
        IDX_ACC_CTRL:
        begin
          rd_word[MODE_MSB:MODE_LSB] = acc_mode_q;
          rd_word[HIT_MSB:0]         = hit_q;
        end
        IDX_TEST_LO:   rd_word = WORD_ZERO;
        IDX_TEST_HI:   rd_word = WORD_ZERO;
        default:       rd_err  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= WORD_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q  <= pwrite ? WORD_ZERO : rd_word;
      pready_q  <= 1'b1;
      pslverr_q <= rd_err;
    end
    else
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign tx_empty      = tx_empty_q;
  assign tx_window_sel = tx_window_sel_q;
  assign rx_fg_load    = rx_fg_load_q;
  assign acc_mode      = acc_mode_q;
  assign fetch_data    = fetch_data_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_read_setup(logic [IDX_W-1:0] at);
    psel && !penable && !pwrite && idx == at;
  endsequence

  sequence s_write_access(logic [IDX_W-1:0] at);
    wr_en && idx == at;
  endsequence

  sequence s_win_setup_closed;
    psel && !penable && win_hit && !win_open;
  endsequence

  a_ack_init_hold: assert property (in_init |=> abort_ack_q == BUF_ZERO)
    else $error("abort acknowledge not held clear in init");

  a_ack_on_abort: assert property (
    (|abort_grant && !in_init) |=>
      ((abort_ack_q & tx_empty_q & $past(abort_grant)) == $past(abort_grant)))
    else $error("abort did not set acknowledge with empty flag");

  a_ack_not_sent: assert property (
    (|(tx_stat.sent & ~tx_empty_q & ~abort_grant) && abort_ack_q == BUF_ZERO
     && !in_init) |=> (abort_ack_q & ~$past(abort_grant)) == BUF_ZERO)
    else $error("successful send raised acknowledge");

  a_ack_follows_txe: assert property (
    |($past(tx_empty_q) & ~tx_empty_q) |->
      (abort_ack_q & $past(tx_empty_q) & ~tx_empty_q) == BUF_ZERO)
    else $error("acknowledge survived empty flag clear");

  a_ack_read_only: assert property (
    (s_write_access(IDX_ABORT_ACK) and (abort_grant == BUF_ZERO &&
     txe_clear == BUF_ZERO && !in_init)) |=> $stable(abort_ack_q))
    else $error("write changed acknowledge flags");

  a_sel_readback: assert property (
    s_read_setup(IDX_TX_SEL) |=>
      $onehot0(prdata_q[BUF_MSB:0]) && prdata_q[DATA_W-1:NBUF] == '0 &&
      (prdata_q[BUF_MSB:0] & ~$past(tx_sel_q)) == BUF_ZERO)
    else $error("select readback not lowest bit");

  a_sel_init: assert property (in_init |=> tx_sel_q == BUF_ZERO)
    else $error("select not held reset in init");

  a_win_blocked: assert property (s_win_setup_closed |=> pslverr_q && pready_q)
    else $error("window access allowed while blocked");

  a_acc_gate: assert property (
    (s_write_access(IDX_ACC_CTRL) and !in_init) |=> $stable(acc_mode_q))
    else $error("acceptance mode written outside init");

  a_closed_noload: assert property (
    filter_closed ##1 filter_closed |-> !rx_fg_load_q)
    else $error("foreground loaded with filter closed");

  a_hit_update: assert property (
    (rx_evt.shift && !filter_closed) |=>
      hit_q == $past(rx_evt.hit) && rx_fg_load_q)
    else $error("hit index not updated on foreground load");

  a_test_zero: assert property (
    (s_read_setup(IDX_TEST_LO) or s_read_setup(IDX_TEST_HI)) |=>
      prdata_q == WORD_ZERO && !pslverr_q)
    else $error("reserved register read nonzero");

  a_req_cleared: assert property (
    |tx_set |=> (abort_req_q & $past(tx_set)) == BUF_ZERO)
    else $error("abort request kept after empty set");

endmodule : can_tx_select_abort_filter_ctrl

// ===== tb/apb_host.sv
// APB host model that stands in for the CPU software.
// Assumes pready and pslverr come back from the block on pclk.
`timescale 1ns/1ps
module apb_host
  import can_txsel_pkg::*;
(
  input  wire logic              pclk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [7:0]        paddr,
  output logic      [DATA_W-1:0] pwdata,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  logic [DATA_W-1:0] rdata;
  logic              rerr;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = WORD_ZERO;
  end

  task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx,
                      input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready.
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale write data is inverted so that nothing relies on it.
    pwdata <= ~d;
  endtask : xfer

  task automatic next_free;
    xfer(1'b0, IDX_TX_FLAG, WORD_ZERO);
    xfer(1'b1, IDX_TX_SEL, rdata);
  endtask : next_free
endmodule : apb_host

// ===== tb/can_tx_select_abort_filter_ctrl_test.sv
// Self-checking bench for the transmit select and acceptance block.
// Assumes the APB host model drives the register bus.
`timescale 1ns/1ps
module can_tx_select_abort_filter_ctrl_test;
  import can_txsel_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              init_request;
  logic              init_acknowledge;
  tx_status_t        tx_stat;
  rx_event_t         rx_evt;
  logic [1:0]        fetch_buf;
  logic [1:0]        fetch_word;
  logic [7:0]        fetch_data;
  logic [NBUF-1:0]   tx_empty;
  logic [NBUF-1:0]   tx_window_sel;
  logic              rx_fg_load;
  acc_mode_t         acc_mode;
  logic [DATA_W-1:0] rdv;
  logic              rer;
  logic [NBUF-1:0]   m_empty;
  int                m_hit;
  int                error_cnt = 0;
  int                n_tests = 0;
  logic [DATA_W-1:0] d;

  always #20 pclk = ~pclk;
  assign rdv = apb_host_inst.rdata;
  assign rer = apb_host_inst.rerr;

  can_tx_select_abort_filter_ctrl can_tx_select_abort_filter_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .init_request(init_request),
    .init_acknowledge(init_acknowledge), .tx_stat(tx_stat),
    .rx_evt(rx_evt), .fetch_buf(fetch_buf), .fetch_word(fetch_word),
    .fetch_data(fetch_data), .tx_empty(tx_empty),
    .tx_window_sel(tx_window_sel), .rx_fg_load(rx_fg_load),
    .acc_mode(acc_mode));

  apb_host apb_host_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic check(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] v);
    apb_host_inst.xfer(1'b1, idx, v);
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx);
    apb_host_inst.xfer(1'b0, idx, WORD_ZERO);
  endtask : rd

  // Scans from the top down so the lowest set bit is the one kept.
  function automatic logic [NBUF-1:0] low(input logic [NBUF-1:0] v);
    logic [NBUF-1:0] r;
    r = BUF_ZERO;
    for (int i = NBUF - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r    = BUF_ZERO;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : low

  task automatic end_of_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    presetn = 1'b0;
    init_request = 1'b0;
    init_acknowledge = 1'b0;
    tx_stat = '0;
    rx_evt = '0;
    fetch_buf = 2'h0;
    fetch_word = 2'h0;
    m_empty = TX_EMPTY_RST;
    m_hit = 0;
    void'($urandom(28546));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_ABORT_ACK);
    check(rdv, WORD_ZERO);
    wr(IDX_TEST_HI, 32'hFFFFFFFF);
    rd(IDX_TEST_HI);
    check(rdv, WORD_ZERO);
    rd(IDX_TEST_LO);
    check(rdv, WORD_ZERO);
    rd(6'h3F);
    for (int i = 0; i < 8; i++)
    begin
      wr(IDX_TX_SEL, ($urandom() & 32'hFFFFFF00) | 32'(i));
      rd(IDX_TX_SEL);
      check(rdv, 32'(low(3'(i))));
      check(32'(tx_window_sel), 32'(low(3'(i))));
    end
    wr(IDX_TX_SEL, WORD_ZERO);
    rd(IDX_WIN_BASE);
    check(32'(rer), 32'h1);
    d = $urandom();
    wr(IDX_TX_SEL, 32'h4);
    wr(IDX_WIN_BASE + 6'h01, d);
    rd(IDX_WIN_BASE + 6'h01);
    check(rdv, 32'(d[7:0]));
    fetch_buf <= 2'h2;
    fetch_word <= 2'h1;
    repeat (2) @(posedge pclk);
    #1;
    check(32'(fetch_data), 32'(d[7:0]));
    wr(IDX_TX_FLAG, 32'h1);
    m_empty[0] = 1'b0;
    apb_host_inst.next_free();
    rd(IDX_TX_SEL);
    check(rdv, 32'(low(m_empty)));
    wr(IDX_TX_SEL, 32'h1);
    rd(IDX_WIN_BASE);
    check(32'(rer), 32'h1);
    check(32'(tx_window_sel), WORD_ZERO);
    // A busy buffer keeps its request until the frame fails.
    tx_stat.busy <= 3'h1;
    wr(IDX_ABORT_REQ, 32'h1);
    repeat (3) @(posedge pclk);
    check(32'(tx_empty), 32'(m_empty));
    tx_stat.failed <= 3'h1;
    @(posedge pclk);
    tx_stat <= '0;
    m_empty[0] = 1'b1;
    repeat (2) @(posedge pclk);
    check(32'(tx_empty), 32'(m_empty));
    rd(IDX_ABORT_REQ);
    check(rdv, WORD_ZERO);
    wr(IDX_ABORT_ACK, WORD_ZERO);
    rd(IDX_ABORT_ACK);
    check(rdv, 32'h1);
    wr(IDX_TX_FLAG, 32'h1);
    m_empty[0] = 1'b0;
    rd(IDX_ABORT_ACK);
    check(rdv, WORD_ZERO);
    wr(IDX_TX_FLAG, 32'h2);
    m_empty[1] = 1'b0;
    tx_stat.sent <= 3'h2;
    @(posedge pclk);
    tx_stat <= '0;
    m_empty[1] = 1'b1;
    repeat (2) @(posedge pclk);
    check(32'(tx_empty), 32'(m_empty));
    rd(IDX_ABORT_ACK);
    check(rdv, WORD_ZERO);
    wr(IDX_ABORT_REQ, 32'h1);
    m_empty[0] = 1'b1;
    repeat (2) @(posedge pclk);
    rd(IDX_ABORT_ACK);
    check(rdv, 32'h1);
    check(32'(tx_empty), 32'(m_empty));
    init_request <= 1'b1;
    init_acknowledge <= 1'b1;
    rd(IDX_ABORT_ACK);
    check(rdv, WORD_ZERO);
    wr(IDX_TX_SEL, 32'h2);
    rd(IDX_TX_SEL);
    check(rdv, WORD_ZERO);
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_ACC_CTRL, 32'(m << MODE_LSB) | 32'h7);
      d = $urandom_range(7);
      rx_evt <= {1'b1, d[2:0]};
      #1;
      check(32'(acc_mode), 32'(m));
      @(posedge pclk);
      rx_evt <= '0;
      #1;
      check(32'(rx_fg_load), 32'(m != 3));
      if (m != 3)
        m_hit = int'(d[2:0]);
      rd(IDX_ACC_CTRL);
      check(rdv, 32'((m << MODE_LSB) | m_hit));
    end
    init_request <= 1'b0;
    init_acknowledge <= 1'b0;
    wr(IDX_ACC_CTRL, WORD_ZERO);
    rd(IDX_ACC_CTRL);
    check(rdv, 32'((3 << MODE_LSB) | m_hit));
    end_of_test();
  end
endmodule : can_tx_select_abort_filter_ctrl_test
